/* rtl/rpm_params.svh */
// Register offsets, field positions and reset values of the receive-port monitor
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH

// Register offsets on the local register port
`define RPM_ADDR_PORT_STS 8'h4D
`define RPM_ADDR_LINK_STS 8'h4E
`define RPM_ADDR_RATE_INT 8'h4F
`define RPM_ADDR_RATE_FRAC 8'h50
`define RPM_ADDR_PAR_UPPER 8'h55
`define RPM_ADDR_PAR_LOWER 8'h56
`define RPM_ADDR_SELFTEST 8'h57
`define RPM_ADDR_SETUP 8'h58

// Field positions in control_channel_setup
`define RPM_SETUP_FWD_ALL 7
`define RPM_SETUP_FWD_MATCH 6
`define RPM_SETUP_ACK_ALL 5
`define RPM_SETUP_RET_FORCED 4

// Field positions in the link status register
`define RPM_STS_SETTLED 2
`define RPM_STS_CLK_ABSENT 1
`define RPM_STS_LINE_CHG 0

// Field positions in the port status register
`define RPM_PSTS_OVER_LIMIT 2
`define RPM_PSTS_LOCKED 0

// Reset values
`define RPM_SETUP_RESET 8'h10
`define RPM_BYTE_RESET 8'h00

`endif

/* rtl/rpm_pkg.sv */
// Types shared by the receive-port monitor modules
package rpm_pkg;

    // Coherent 8.8 fixed-point megahertz value
    typedef struct packed {
        logic [7:0] integerMhz;
        logic [7:0] fraction;
    } rpm_rate_type;

    // One register access from the local register port
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic fromRemote;
        logic [7:0] addr;
        logic [7:0] wrData;
    } rpm_regreq_type;

    // Receiver events and levels, all on mclk
    typedef struct packed {
        logic locked;
        logic clockAbsent;
        logic lineTotalChange;
        logic parityMiss;
        logic selftestMiss;
    } rpm_link_ev_type;

    // Rate measurement tracking
    typedef enum logic [1:0] {
        MEAS_WAIT,
        MEAS_TRACK,
        MEAS_SETTLED
    } rpm_meas_state_type;

endpackage

/* rtl/rpm_err_count.sv */
// Saturating event counter with a clear that restarts the count at one on a same-cycle event
`timescale 1ns/1ps
module rpm_err_count #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic inc,
    input wire logic clear,
    output logic [WIDTH-1:0] count_q
);
    logic [WIDTH-1:0] count_d;
    wire atMax = &count_q;

    // Clear restarts at one when an event lands in the same cycle
    assign count_d = clear ? {{(WIDTH-1){1'b0}}, inc} : (inc && !atMax) ? count_q + 1'b1 : count_q;

    // Count register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
        end else if (ce) begin
            count_q <= count_d;
        end
    end
endmodule // rpm_err_count

/* rtl/rpm_rate_meter.sv */
// Holds the measured link rate and judges whether it has settled
`timescale 1ns/1ps
module rpm_rate_meter (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic sampleValid,
    input rpm_pkg::rpm_rate_type sample,
    input wire logic clockAbsent,
    output rpm_pkg::rpm_rate_type rate_q,
    output logic settled_q
);
    rpm_pkg::rpm_meas_state_type state_q;
    rpm_pkg::rpm_meas_state_type state_d;
    wire sameAsLast = (sample == rate_q);

    // Settling decision: two equal measurements in a row, lost with the clock
    always_comb begin
        state_d = state_q;
        case (state_q)
            rpm_pkg::MEAS_WAIT: begin
                if (sampleValid) begin
                    state_d = rpm_pkg::MEAS_TRACK;
                end
            end
            rpm_pkg::MEAS_TRACK, rpm_pkg::MEAS_SETTLED: begin
                if (sampleValid) begin
                    state_d = sameAsLast ? rpm_pkg::MEAS_SETTLED : rpm_pkg::MEAS_TRACK;
                end
            end
            default: begin
                state_d = rpm_pkg::MEAS_WAIT;
            end
        endcase
        if (clockAbsent) begin
            state_d = rpm_pkg::MEAS_WAIT;
        end
    end

    // Both bytes load from one sample so software never sees a torn value
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rate_q <= '0;
            state_q <= rpm_pkg::MEAS_WAIT;
            settled_q <= 1'b0;
        end else if (ce) begin
            if (sampleValid) begin
                rate_q <= sample;
            end
            state_q <= state_d;
            settled_q <= (state_d == rpm_pkg::MEAS_SETTLED);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_rate_coherent: assert property (ce && sampleValid |=> rate_q == $past(sample))
        else $error("rate bytes not loaded together from one sample");
    a_settled_drop: assert property (ce && clockAbsent |=> !settled_q)
        else $error("settled flag stayed high with no input clock");
    a_settled_agree: assert property (ce && !clockAbsent && sampleValid && state_q != rpm_pkg::MEAS_WAIT
        && !sameAsLast |=> !settled_q)
        else $error("settled flag high after a differing measurement");
endmodule // rpm_rate_meter

/* rtl/rpm_top.sv */
// Receive-port status registers and control-channel setup register
`timescale 1ns/1ps
`include "rpm_params.svh"
module rpm_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input rpm_pkg::rpm_regreq_type regReq,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input rpm_pkg::rpm_link_ev_type linkEv,
    input wire logic rateSampleValid,
    input rpm_pkg::rpm_rate_type rateSample,
    input wire logic parityCheckOn,
    input wire logic [15:0] parityThreshold,
    output logic forwardAll,
    output logic forwardOnMatch,
    output logic ackAllWrites,
    output logic backChannelEnable
);
    // Held registers
    logic [7:0] setup_q;
    logic [7:0] setup_d;
    logic lineChange_q;
    logic lineChange_d;
    logic overLimit_q;
    logic overLimit_d;
    logic locked_q;
    logic clockAbsent_q;
    logic [7:0] rdData_q;
    logic rdValid_q;
    logic backChannel_q;

    // Sub-block results
    rpm_pkg::rpm_rate_type rate;
    logic settled;
    logic [15:0] parCount;
    logic [7:0] selftestCount;

    // Address decode of the register port
    wire rdPortSts = regReq.rdEn && (regReq.addr == `RPM_ADDR_PORT_STS);
    wire rdLinkSts = regReq.rdEn && (regReq.addr == `RPM_ADDR_LINK_STS);
    wire rdRateInt = regReq.rdEn && (regReq.addr == `RPM_ADDR_RATE_INT);
    wire rdRateFrac = regReq.rdEn && (regReq.addr == `RPM_ADDR_RATE_FRAC);
    wire rdParUpper = regReq.rdEn && (regReq.addr == `RPM_ADDR_PAR_UPPER);
    wire rdParLower = regReq.rdEn && (regReq.addr == `RPM_ADDR_PAR_LOWER);
    wire rdSelftest = regReq.rdEn && (regReq.addr == `RPM_ADDR_SELFTEST);
    wire rdSetup = regReq.rdEn && (regReq.addr == `RPM_ADDR_SETUP);
    wire wrSetup = regReq.wrEn && (regReq.addr == `RPM_ADDR_SETUP);

    // Lock edge restarts parity counting; lower-byte read clears both bytes
    wire lockRise = linkEv.locked && !locked_q;
    wire parClear = lockRise || rdParLower;
    wire parInc = linkEv.parityMiss && parityCheckOn;

    // Status bytes assembled from live state
    wire [7:0] portStsByte = {5'h00, overLimit_q, 1'b0, locked_q};
    wire [7:0] linkStsByte = {5'h00, settled, clockAbsent_q, lineChange_q};

    // Read selection, unmapped offsets read zero
    wire [7:0] rdMux =
        rdPortSts ? portStsByte :
        rdLinkSts ? linkStsByte :
        rdRateInt ? rate.integerMhz :
        rdRateFrac ? rate.fraction :
        rdParUpper ? parCount[15:8] :
        rdParLower ? parCount[7:0] :
        rdSelftest ? selftestCount :
        rdSetup ? setup_q :
        `RPM_BYTE_RESET;

    // Setup write; remote writes cannot touch the forced-on bit
    wire forcedBitNext = regReq.fromRemote ? setup_q[`RPM_SETUP_RET_FORCED]
                                           : regReq.wrData[`RPM_SETUP_RET_FORCED];
    assign setup_d = wrSetup ? {regReq.wrData[7:5], forcedBitNext, 4'h0} : setup_q;

    // Line-change flag: a new change wins over the clearing read
    assign lineChange_d = linkEv.lineTotalChange || (lineChange_q && !rdLinkSts);

    // Over-limit flag follows the count, cleared together with it
    assign overLimit_d = parClear ? 1'b0 : (overLimit_q || (parCount > parityThreshold));

    // Back channel: forced on, or enabled by either forwarding mode
    wire backChannelNext = setup_q[`RPM_SETUP_RET_FORCED]
        || setup_q[`RPM_SETUP_FWD_ALL] || setup_q[`RPM_SETUP_FWD_MATCH];

    // Link rate measurement and settling
    rpm_rate_meter u_rate (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .sampleValid(rateSampleValid),
        .sample(rateSample),
        .clockAbsent(linkEv.clockAbsent),
        .rate_q(rate),
        .settled_q(settled)
    );

    // Sixteen-bit parity miss counter
    rpm_err_count #(.WIDTH(16)) u_parity (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .inc(parInc),
        .clear(parClear),
        .count_q(parCount)
    );

    // Self-test error counter, cleared only by reset
    rpm_err_count #(.WIDTH(8)) u_selftest (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .inc(linkEv.selftestMiss),
        .clear(1'b0),
        .count_q(selftestCount)
    );

    // Control and status flags
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            setup_q <= `RPM_SETUP_RESET;
            lineChange_q <= 1'b0;
            overLimit_q <= 1'b0;
            locked_q <= 1'b0;
            clockAbsent_q <= 1'b0;
            backChannel_q <= 1'b0;
        end else if (ce) begin
            setup_q <= setup_d;
            lineChange_q <= lineChange_d;
            overLimit_q <= overLimit_d;
            locked_q <= linkEv.locked;
            clockAbsent_q <= linkEv.clockAbsent;
            backChannel_q <= backChannelNext;
        end
    end

    // Read answer, one cycle after the request
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdData_q <= `RPM_BYTE_RESET;
            rdValid_q <= 1'b0;
        end else if (ce) begin
            rdData_q <= regReq.rdEn ? rdMux : rdData_q;
            rdValid_q <= regReq.rdEn;
        end
    end

    // Outputs straight from flops
    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;
    assign forwardAll = setup_q[`RPM_SETUP_FWD_ALL];
    assign forwardOnMatch = setup_q[`RPM_SETUP_FWD_MATCH];
    assign ackAllWrites = setup_q[`RPM_SETUP_ACK_ALL];
    assign backChannelEnable = backChannel_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_lower_read_clears: assert property (ce && rdParLower && !parInc |=> parCount == 16'h0000)
        else $error("lower parity read did not clear the count");
    a_upper_cleared_too: assert property (ce && rdParLower |=> parCount[15:8] == 8'h00)
        else $error("lower parity read left the upper byte");
    a_lock_restarts: assert property (ce && linkEv.locked && !locked_q |=> parCount <= 16'h0001)
        else $error("parity count not restarted on new lock");
    a_lock_status: assert property (ce && rdPortSts ##1 ce |-> regRdData[0] == $past(locked_q, 1))
        else $error("locked status read wrong");
    a_line_set: assert property (ce && linkEv.lineTotalChange |=> lineChange_q)
        else $error("line change event lost");
    a_line_clear: assert property (ce && rdLinkSts && !linkEv.lineTotalChange |=> !lineChange_q)
        else $error("line change flag survived its read");
    a_clk_absent: assert property (ce && rdLinkSts |=> regRdValid && regRdData[1] == $past(clockAbsent_q))
        else $error("clock-absent bit read wrong");
    a_rate_int_read: assert property (ce && rdRateInt |=> regRdData == $past(rate.integerMhz))
        else $error("integer rate read wrong");
    a_rate_frac_read: assert property (ce && rdRateFrac |=> regRdData == $past(rate.fraction))
        else $error("fractional rate read wrong");
    a_selftest_read: assert property (ce && rdSelftest |=> regRdData == $past(selftestCount))
        else $error("self-test count read wrong");
    a_remote_forced: assert property (ce && wrSetup && regReq.fromRemote
        |=> setup_q[4] == $past(setup_q[4]))
        else $error("remote write changed the forced-on bit");
    a_forward_bits: assert property (ce && wrSetup |=> forwardAll == $past(regReq.wrData[7])
        && forwardOnMatch == $past(regReq.wrData[6]) && ackAllWrites == $past(regReq.wrData[5]))
        else $error("forwarding bits not taken from the write");
    a_back_channel: assert property (ce && wrSetup && !regReq.fromRemote ##1 ce
        |=> backChannelEnable == ($past(regReq.wrData[4], 2) || $past(regReq.wrData[7], 2)
        || $past(regReq.wrData[6], 2)))
        else $error("back channel enable wrong after setup write");
    a_over_limit: assert property (ce && !parClear && parCount > parityThreshold |=> overLimit_q)
        else $error("over-limit not set above threshold");
    a_over_clear: assert property (ce && parClear |=> !overLimit_q)
        else $error("over-limit not cleared with the count");

    // Every read gets exactly one answer carrying the value at the taking edge
    a_read_valid: assert property (ce && regReq.rdEn |=> regRdValid)
        else $error("read request got no answer");
    a_no_read_idle: assert property (ce && !regReq.rdEn |=> !regRdValid)
        else $error("answer without a read request");
    a_par_upper_read: assert property (ce && rdParUpper |=> regRdData == $past(parCount[15:8]))
        else $error("upper parity byte read wrong");
    a_par_lower_read: assert property (ce && rdParLower |=> regRdData == $past(parCount[7:0]))
        else $error("lower parity byte read wrong");
    a_line_read: assert property (ce && rdLinkSts |=> regRdData[0] == $past(lineChange_q))
        else $error("line change bit read wrong");
    a_settled_read: assert property (ce && rdLinkSts |=> regRdData[2] == $past(settled))
        else $error("settled bit read wrong");
    a_over_read: assert property (ce && rdPortSts |=> regRdData[2] == $past(overLimit_q))
        else $error("over-limit bit read wrong");
    a_setup_read: assert property (ce && rdSetup |=> regRdData == $past(setup_q))
        else $error("setup register read wrong");

    // Counters step by one per event and hold otherwise
    a_par_step: assert property (ce && parInc && !parClear && parCount != 16'hFFFF
        |=> parCount == $past(parCount) + 16'h0001)
        else $error("parity count did not step");
    a_par_hold: assert property (ce && !parInc && !parClear |=> parCount == $past(parCount))
        else $error("parity count moved without an event");
    a_par_saturate: assert property (ce && parInc && !parClear && parCount == 16'hFFFF |=> parCount == 16'hFFFF)
        else $error("parity count wrapped");
    a_selftest_step: assert property (ce && linkEv.selftestMiss && selftestCount != 8'hFF
        |=> selftestCount == $past(selftestCount) + 8'h01)
        else $error("self-test count did not step");
    a_selftest_hold: assert property (ce && !linkEv.selftestMiss |=> selftestCount == $past(selftestCount))
        else $error("self-test count moved without an event");

    // Status levels and sticky flags
    a_lock_follow: assert property (ce |=> locked_q == $past(linkEv.locked))
        else $error("locked status does not follow the receiver");
    a_clk_follow: assert property (ce |=> clockAbsent_q == $past(linkEv.clockAbsent))
        else $error("clock-absent status does not follow the link");
    a_line_hold: assert property (ce && lineChange_q && !rdLinkSts |=> lineChange_q)
        else $error("line change flag lost without a read");
    a_over_hold: assert property (ce && overLimit_q && !parClear |=> overLimit_q)
        else $error("over-limit flag lost without a clear");

    // Setup register and the enables it drives
    a_local_forced: assert property (ce && wrSetup && !regReq.fromRemote
        |=> setup_q[4] == $past(regReq.wrData[4]))
        else $error("local write did not set the forced-on bit");
    a_setup_hold: assert property (ce && !wrSetup |=> setup_q == $past(setup_q))
        else $error("setup changed without a setup write");
    a_back_follow: assert property (ce |=> backChannelEnable == $past(setup_q[4] || setup_q[7] || setup_q[6]))
        else $error("back channel enable does not follow the setup");

    // Clock enable low freezes the register state and the read answer
    a_ce_freeze: assert property (!ce |=> setup_q == $past(setup_q) && parCount == $past(parCount)
        && selftestCount == $past(selftestCount) && regRdValid == $past(regRdValid))
        else $error("state moved with clock enable low");

    c_lower_read: cover property (ce && rdParLower && parCount != 16'h0000);
    c_remote_write: cover property (ce && wrSetup && regReq.fromRemote);
    c_over_limit: cover property (ce && overLimit_q);
    c_settled: cover property (ce && settled);
    c_lock_restart: cover property (ce && lockRise && parCount != 16'h0000);
endmodule // rpm_top

/* dv/rpm_link_model.sv */
// Behavioural receive-link source: lock and clock levels, event pulses and rate samples
`timescale 1ns/1ps
module rpm_link_model (
    input wire logic mclk,
    output rpm_pkg::rpm_link_ev_type linkEv,
    output logic rateSampleValid,
    output rpm_pkg::rpm_rate_type rateSample
);
    // Quiet link at time zero
    initial begin
        linkEv = '0;
        rateSampleValid = 1'b0;
        rateSample = '0;
    end

    // Lock and clock-presence levels, changed just after an edge
    task automatic set_levels(input logic lk, input logic noClk);
        @(posedge mclk);
        #1;
        linkEv.locked = lk;
        linkEv.clockAbsent = noClk;
    endtask

    // Kind 0 parity miss, 1 line total change, 2 self-test miss; n back-to-back cycles
    task automatic pulse_ev(input int kind, input int n);
        for (int i = 0; i <= n; i++) begin
            @(posedge mclk);
            #1;
            linkEv.parityMiss = (kind == 0) && (i < n);
            linkEv.lineTotalChange = (kind == 1) && (i < n);
            linkEv.selftestMiss = (kind == 2) && (i < n);
        end
    endtask

    // One measurement as a single word; afterwards the bus shows its inverse
    task automatic send_rate(input rpm_pkg::rpm_rate_type r);
        @(posedge mclk);
        #1;
        rateSampleValid = 1'b1;
        rateSample = r;
        @(posedge mclk);
        #1;
        rateSampleValid = 1'b0;
        rateSample = ~r;
    endtask
endmodule // rpm_link_model

/* dv/rx_port_monitor_and_ctrl_chan_cfg_tb_top.sv */
// Self-checking bench for the receive-port monitor and control-channel setup registers
`timescale 1ns/1ps
module rx_port_monitor_and_ctrl_chan_cfg_tb_top;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    rpm_pkg::rpm_regreq_type regReq = '0;
    logic [7:0] regRdData;
    logic regRdValid;
    rpm_pkg::rpm_link_ev_type linkEv;
    logic rateSampleValid;
    rpm_pkg::rpm_rate_type rateSample;
    logic parityCheckOn = 1'b0;
    logic [15:0] parityThreshold = 16'h0005;
    logic forwardAll, forwardOnMatch, ackAllWrites, backChannelEnable;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;
    logic [7:0] setupExp, d;
    logic rem;
    logic [15:0] r;
    logic [7:0] corner [5] = '{8'h00, 8'h40, 8'h80, 8'hE0, 8'hF0};

    always #25 mclk = ~mclk;

    rpm_top rpm_top_i (.mclk(mclk), .reset(reset), .ce(ce), .regReq(regReq), .regRdData(regRdData),
        .regRdValid(regRdValid), .linkEv(linkEv), .rateSampleValid(rateSampleValid), .rateSample(rateSample),
        .parityCheckOn(parityCheckOn), .parityThreshold(parityThreshold), .forwardAll(forwardAll),
        .forwardOnMatch(forwardOnMatch), .ackAllWrites(ackAllWrites), .backChannelEnable(backChannelEnable));
    rpm_link_model rpm_link_model_i (.mclk(mclk), .linkEv(linkEv), .rateSampleValid(rateSampleValid),
        .rateSample(rateSample));

    // Verdict and end of run
    task automatic stop_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // One access held for exactly one taking edge
    task automatic access(input logic rd, input logic wr, input logic rm, input logic [7:0] a, input logic [7:0] w);
        @(posedge mclk);
        #1;
        regReq = '{wrEn: wr, rdEn: rd, fromRemote: rm, addr: a, wrData: w};
        @(posedge mclk);
        #1;
        regReq = '0;
    endtask

    // Read answer is looked at in its single valid cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        access(1'b1, 1'b0, 1'b0, a, 8'h00);
        chk(regRdValid === 1'b1 && regRdData === exp, $sformatf("read of %h gave %h", a, regRdData));
    endtask

    // Setup value after a write; the control channel cannot move the forced-on bit
    function automatic logic [7:0] setup_next(input logic [7:0] old, input logic [7:0] w, input logic rm);
        return rm ? {w[7:5], old[4], 4'h0} : {w[7:4], 4'h0};
    endfunction

    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'h4155BEFF));
        repeat (20) @(posedge mclk);
        #1;
        reset = 1'b0;
        rpm_link_model_i.set_levels(1'b1, 1'b0);
        chk(backChannelEnable === 1'b1 && forwardAll === 1'b0, "reset outputs");
        rd_chk(8'h4F, 8'h00);
        rd_chk(8'h50, 8'h00);
        rd_chk(8'h55, 8'h00);
        rd_chk(8'h56, 8'h00);
        rd_chk(8'h57, 8'h00);
        rd_chk(8'h58, 8'h10);
        rd_chk(8'h20, 8'h00);
        access(1'b0, 1'b1, 1'b0, 8'h4F, 8'hFF);
        rd_chk(8'h4F, 8'h00);
        setupExp = 8'h10;
        // Corner setups first, then random ones, some arriving from the remote side
        for (int i = 0; i < 24; i++) begin
            d = (i < 5) ? corner[i] : 8'($urandom());
            rem = (i < 5) ? (i == 4) : 1'($urandom());
            access(1'b0, 1'b1, rem, 8'h58, d);
            setupExp = setup_next(setupExp, d, rem);
            chk(forwardAll === setupExp[7] && forwardOnMatch === setupExp[6], "forward bits");
            chk(ackAllWrites === setupExp[5], "local ack bit");
            // Back channel enable follows the new setup one cycle later
            @(posedge mclk);
            #1;
            chk(backChannelEnable === (setupExp[4] | setupExp[7] | setupExp[6]), "back channel");
            rd_chk(8'h58, setupExp);
        end
        // Two equal samples settle the meter, a different one unsettles it
        r = 16'($urandom());
        rpm_link_model_i.send_rate(r);
        rpm_link_model_i.send_rate(r);
        rd_chk(8'h4F, r[15:8]);
        rd_chk(8'h50, r[7:0]);
        rd_chk(8'h4E, 8'h04);
        rpm_link_model_i.send_rate(~r);
        rd_chk(8'h4F, ~r[15:8]);
        rd_chk(8'h4E, 8'h00);
        rpm_link_model_i.set_levels(1'b1, 1'b1);
        rd_chk(8'h4E, 8'h02);
        rpm_link_model_i.set_levels(1'b1, 1'b0);
        rpm_link_model_i.pulse_ev(1, 1);
        rd_chk(8'h4E, 8'h01);
        rd_chk(8'h4E, 8'h00);
        rd_chk(8'h4D, 8'h01);
        // Parity count across the byte boundary, checker off before reading
        parityCheckOn = 1'b1;
        n = 256 + int'($urandom() % 64);
        rpm_link_model_i.pulse_ev(0, n);
        parityCheckOn = 1'b0;
        rd_chk(8'h4D, 8'h05);
        rd_chk(8'h55, 8'(n >> 8));
        rd_chk(8'h56, 8'(n));
        rd_chk(8'h55, 8'h00);
        rd_chk(8'h56, 8'h00);
        rd_chk(8'h4D, 8'h01);
        // New lock restarts the count
        parityCheckOn = 1'b1;
        rpm_link_model_i.pulse_ev(0, 3);
        rpm_link_model_i.set_levels(1'b0, 1'b0);
        rpm_link_model_i.set_levels(1'b0, 1'b0);
        rpm_link_model_i.set_levels(1'b1, 1'b0);
        rpm_link_model_i.pulse_ev(0, 2);
        parityCheckOn = 1'b0;
        rd_chk(8'h55, 8'h00);
        rd_chk(8'h56, 8'h02);
        n = 1 + int'($urandom() % 10);
        rpm_link_model_i.pulse_ev(2, n);
        rd_chk(8'h57, 8'(n));
        // Clock enable low freezes every flop: a setup write and self-test misses are lost
        ce = 1'b0;
        access(1'b0, 1'b1, 1'b0, 8'h58, ~setupExp);
        rpm_link_model_i.pulse_ev(2, 3);
        ce = 1'b1;
        chk(forwardAll === setupExp[7] && ackAllWrites === setupExp[5], "write taken with clock enable low");
        rd_chk(8'h58, setupExp);
        rd_chk(8'h57, 8'(n));
        // Mid-run reset brings back the reset values
        reset = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk(regRdValid === 1'b0 && forwardAll === 1'b0 && backChannelEnable === 1'b0, "outputs in reset");
        reset = 1'b0;
        rd_chk(8'h57, 8'h00);
        rd_chk(8'h58, 8'h10);
        chk(backChannelEnable === 1'b1, "back channel after reset");
        stop_test();
    end
endmodule // rx_port_monitor_and_ctrl_chan_cfg_tb_top
